// ==== fp_slice_pkg.sv ====
package fp_slice_pkg;
    localparam int WORD_W   = 64;
    localparam int XFER_W   = 16;
    localparam int SECTORS  = 4;
    localparam int SLICES   = 16;
    localparam int RF_DEPTH = 16;
    localparam int RF_AW    = 4;
    localparam int IR_W     = 12;

    // Instruction register fields feeding the address multiplexers
    localparam int IR_SD_LSB = 0;
    localparam int IR_SD_W   = 3;
    localparam int IR_AC_LSB = 6;
    localparam int IR_AC_W   = 2;
    localparam logic [IR_W-1:0] IR_RESET = 12'h000;

    // Scratch-pad map (octal in comments)
    localparam int          ACC_COUNT     = 6;
    localparam logic [3:0]  UNUSED_LOC_LO = 4'h6;  // 6
    localparam logic [3:0]  UNUSED_LOC_HI = 4'h7;  // 7
    localparam logic [3:0]  WORK_FIRST    = 4'h8;  // 10
    localparam logic [3:0]  WORK_LAST     = 4'hC;  // 14
    localparam logic [3:0]  ERR_ADDR_LOC  = 4'hD;  // 15, error_address_word and error_address_scratch
    localparam logic [3:0]  ERR_CODE_LOC  = 4'hE;  // 16, error_code_word and special_work_reg_a
    localparam logic [3:0]  SPECIAL_LOC   = 4'hF;  // 17, special_work_reg_b

    // Register port
    localparam logic [1:0]  REG_IR     = 2'h0;
    localparam logic [1:0]  REG_STATUS = 2'h1;
    localparam int          ST_CARRY   = 0;
    localparam int          ST_ZERO    = 1;
    localparam int          ST_SIGN    = 2;
    localparam int          ST_OVF     = 3;
    localparam int          ST_BUSY    = 4;

    typedef enum logic [1:0] {PSEL_CTL, PSEL_IR_SD, PSEL_IR_AC} port_sel_e;
    typedef enum logic [2:0] {SRC_AQ, SRC_AB, SRC_ZQ, SRC_ZB, SRC_ZA, SRC_DA, SRC_DQ, SRC_DZ} alu_src_e;
    typedef enum logic [2:0] {FN_ADD, FN_SUBR, FN_SUBS, FN_OR, FN_AND, FN_NOTRS, FN_EXOR, FN_EXNOR} alu_fn_e;
    typedef enum logic [2:0] {DST_QREG, DST_NOP, DST_RAMA, DST_RAMF, DST_RAMQD, DST_RAMD, DST_RAMQU,
                              DST_RAMU} alu_dst_e;
    typedef enum logic [1:0] {FILL_ZERO, FILL_ONE, FILL_ROT, FILL_CARRY} shift_fill_e;
endpackage : fp_slice_pkg

// ==== scratch_regfile.sv ====
module scratch_regfile (
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        rd_en,
    input  wire logic [3:0]  a_addr,
    input  wire logic [3:0]  b_addr,
    output logic      [63:0] a_data,
    output logic      [63:0] b_data,
    input  wire logic [3:0]  wr_sector,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [63:0] wr_data
);
    // One RAM per sector so each sector clock loads only its own slice
    genvar s;
    generate
        for (s = 0; s < fp_slice_pkg::SECTORS; s++) begin : g_sector
            logic [15:0] mem [0:fp_slice_pkg::RF_DEPTH-1];
            logic [15:0] a_q;
            logic [15:0] b_q;
            always_ff @(posedge clk) begin
                if (ce && rd_en) begin
                    a_q <= mem[a_addr];
                    b_q <= mem[b_addr];
                end
                if (ce && wr_sector[s]) begin
                    mem[wr_addr] <= wr_data[s*16 +: 16];
                end
            end
            assign a_data[s*16 +: 16] = a_q;
            assign b_data[s*16 +: 16] = b_q;
        end
    endgenerate
endmodule : scratch_regfile

// ==== fp_bit_slice_datapath.sv ====
module fp_bit_slice_datapath (
    input  wire logic                      clk,
    input  wire logic                      srst,
    input  wire logic                      ce,
    input  wire logic                      mc_go,
    input  wire fp_slice_pkg::port_sel_e   a_port_sel,
    input  wire fp_slice_pkg::port_sel_e   b_port_sel,
    input  wire logic [3:0]                a_field,
    input  wire logic [3:0]                b_field,
    input  wire fp_slice_pkg::alu_src_e    alu_source,
    input  wire fp_slice_pkg::alu_fn_e     alu_function,
    input  wire fp_slice_pkg::alu_dst_e    alu_dest,
    input  wire logic                      carry_in,
    input  wire fp_slice_pkg::shift_fill_e shift_fill,
    input  wire logic [3:0]                sector_load,
    input  wire logic [1:0]                word_sel,
    input  wire logic                      xfer_drive,
    input  wire logic                      xfer_from_alu,
    input  wire logic [15:0]               operand_transfer_bus_in,
    output logic      [15:0]               operand_transfer_bus_out,
    output logic                           xfer_out_valid,
    output logic                           mc_done,
    output logic                           busy,
    output logic                           fast_carry_out,
    input  wire logic [1:0]                reg_addr,
    input  wire logic [15:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [15:0]               reg_rdata
);
    typedef enum logic {ST_IDLE, ST_EXEC} state_e;

    state_e                    state,      next_state;
    fp_slice_pkg::alu_src_e    src_q,      next_src;
    fp_slice_pkg::alu_fn_e     fn_q,       next_fn;
    fp_slice_pkg::alu_dst_e    dst_q,      next_dst;
    fp_slice_pkg::shift_fill_e fill_q,     next_fill;
    logic                      cin_q,      next_cin;
    logic [3:0]                sect_q,     next_sect;
    logic [1:0]                word_q,     next_word;
    logic                      drive_q,    next_drive;
    logic                      from_alu_q, next_from_alu;
    logic [15:0]               din_q,      next_din;
    logic [3:0]                wr_addr_q,  next_wr_addr;
    logic [3:0]                a_eff;
    logic [3:0]                b_eff;
    logic                      rd_en;

    logic [11:0]               ir,         next_ir;
    logic [15:0]               next_rdata;
    logic [63:0]               q,          next_q;
    logic [3:0]                flags,      next_flags;
    logic [15:0]               next_xout;
    logic                      next_xvalid;
    logic                      next_done;
    logic                      next_busy;
    logic                      next_fco;

    logic [63:0] a_word, b_word, d_word;
    logic [63:0] r_op, s_op, x_op, y_op, g, p, cb, f, y_out, rf_wdata;
    logic [15:0] sg, sp, sc;
    logic [3:0]  gg, gp;
    logic [4:0]  gc;
    logic        cout, dn_fill, up_fill, q_fill, rf_we;

    function automatic logic [3:0] pick_addr(fp_slice_pkg::port_sel_e sel, logic [3:0] fld, logic [11:0] irv);
        case (sel)
            fp_slice_pkg::PSEL_IR_SD: pick_addr = {1'b0, irv[fp_slice_pkg::IR_SD_LSB +: fp_slice_pkg::IR_SD_W]};
            fp_slice_pkg::PSEL_IR_AC: pick_addr = {2'b00, irv[fp_slice_pkg::IR_AC_LSB +: fp_slice_pkg::IR_AC_W]};
            default:                  pick_addr = fld;
        endcase
    endfunction : pick_addr

    // Look-ahead carries c0..c4 of a four-wide group
    function automatic logic [4:0] cla4(logic [3:0] gi, logic [3:0] pi, logic c0);
        cla4[0] = c0;
        cla4[1] = gi[0] | (pi[0] & c0);
        cla4[2] = gi[1] | (pi[1] & gi[0]) | (&pi[1:0] & c0);
        cla4[3] = gi[2] | (pi[2] & gi[1]) | (&pi[2:1] & gi[0]) | (&pi[2:0] & c0);
        cla4[4] = gi[3] | (pi[3] & gi[2]) | (&pi[3:2] & gi[1]) | (&pi[3:1] & gi[0]) | (&pi & c0);
    endfunction : cla4

    function automatic logic [1:0] gp4(logic [3:0] gi, logic [3:0] pi);
        logic [4:0] c;
        c = cla4(gi, pi, 1'b0);
        gp4 = {c[4], &pi};
    endfunction : gp4

    // Instruction fields give only 0..7, so 10-17 octal stay microcode-only
    assign a_eff = pick_addr(a_port_sel, a_field, ir);
    assign b_eff = pick_addr(b_port_sel, b_field, ir);
    assign rd_en = (state == ST_IDLE) && mc_go;

    scratch_regfile u_rf (
        .clk       (clk),
        .ce        (ce),
        .rd_en     (rd_en),
        .a_addr    (a_eff),
        .b_addr    (b_eff),
        .a_data    (a_word),
        .b_data    (b_word),
        .wr_sector (rf_we ? sect_q : 4'h0),
        .wr_addr   (wr_addr_q),
        .wr_data   (rf_wdata)
    );

    always_comb begin
        next_state = state;
        next_src = src_q;
        next_fn = fn_q;
        next_dst = dst_q;
        next_fill = fill_q;
        next_cin = cin_q;
        next_sect = sect_q;
        next_word = word_q;
        next_drive = drive_q;
        next_from_alu = from_alu_q;
        next_din = din_q;
        next_wr_addr = wr_addr_q;
        next_done = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (mc_go) begin
                    next_state = ST_EXEC;
                    next_src = alu_source;
                    next_fn = alu_function;
                    next_dst = alu_dest;
                    next_fill = shift_fill;
                    next_cin = carry_in;
                    next_sect = sector_load;
                    next_word = word_sel;
                    next_drive = xfer_drive;
                    next_from_alu = xfer_from_alu;
                    next_din = operand_transfer_bus_in;
                    next_wr_addr = b_eff;
                end
            end
            ST_EXEC: begin
                next_state = ST_IDLE;
                next_done = 1'b1;
            end
        endcase
        next_busy = (next_state == ST_EXEC);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            // Transfer word only, so idle operands stay known before any RAM read
            src_q <= fp_slice_pkg::SRC_DZ;
            fn_q <= fp_slice_pkg::FN_ADD;
            dst_q <= fp_slice_pkg::DST_NOP;
            fill_q <= fp_slice_pkg::FILL_ZERO;
            cin_q <= 1'b0;
            sect_q <= 4'h0;
            word_q <= 2'h0;
            drive_q <= 1'b0;
            from_alu_q <= 1'b0;
            din_q <= 16'h0000;
            wr_addr_q <= 4'h0;
            mc_done <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            src_q <= next_src;
            fn_q <= next_fn;
            dst_q <= next_dst;
            fill_q <= next_fill;
            cin_q <= next_cin;
            sect_q <= next_sect;
            word_q <= next_word;
            drive_q <= next_drive;
            from_alu_q <= next_from_alu;
            din_q <= next_din;
            wr_addr_q <= next_wr_addr;
            mc_done <= next_done;
            busy <= next_busy;
        end
    end

    // Transfer-bus word lands in its sector of the D operand
    assign d_word = {48'h0, din_q} << {word_q, 4'h0};

    always_comb begin
        unique case (src_q)
            fp_slice_pkg::SRC_AQ: begin r_op = a_word; s_op = q; end
            fp_slice_pkg::SRC_AB: begin r_op = a_word; s_op = b_word; end
            fp_slice_pkg::SRC_ZQ: begin r_op = 64'h0; s_op = q; end
            fp_slice_pkg::SRC_ZB: begin r_op = 64'h0; s_op = b_word; end
            fp_slice_pkg::SRC_ZA: begin r_op = 64'h0; s_op = a_word; end
            fp_slice_pkg::SRC_DA: begin r_op = d_word; s_op = a_word; end
            fp_slice_pkg::SRC_DQ: begin r_op = d_word; s_op = q; end
            fp_slice_pkg::SRC_DZ: begin r_op = d_word; s_op = 64'h0; end
        endcase
        x_op = (fn_q == fp_slice_pkg::FN_SUBR) ? ~r_op : r_op;
        y_op = (fn_q == fp_slice_pkg::FN_SUBS) ? ~s_op : s_op;
    end

    assign g = x_op & y_op;
    assign p = x_op ^ y_op;

    // Slice level, then group level look-ahead
    genvar i;
    generate
        for (i = 0; i < fp_slice_pkg::SLICES; i++) begin : g_slice
            logic [4:0] bc;
            assign {sg[i], sp[i]} = gp4(g[4*i +: 4], p[4*i +: 4]);
            assign bc = cla4(g[4*i +: 4], p[4*i +: 4], sc[i]);
            assign cb[4*i +: 4] = bc[3:0];
        end
        for (i = 0; i < fp_slice_pkg::SECTORS; i++) begin : g_group
            logic [4:0] scv;
            assign {gg[i], gp[i]} = gp4(sg[4*i +: 4], sp[4*i +: 4]);
            assign scv = cla4(sg[4*i +: 4], sp[4*i +: 4], gc[i]);
            assign sc[4*i +: 4] = scv[3:0];
        end
    endgenerate
    assign gc = cla4(gg, gp, cin_q);
    assign cout = gc[4];

    always_comb begin
        unique case (fn_q)
            fp_slice_pkg::FN_ADD,
            fp_slice_pkg::FN_SUBR,
            fp_slice_pkg::FN_SUBS:  f = p ^ cb;
            fp_slice_pkg::FN_OR:    f = r_op | s_op;
            fp_slice_pkg::FN_AND:   f = r_op & s_op;
            fp_slice_pkg::FN_NOTRS: f = ~r_op & s_op;
            fp_slice_pkg::FN_EXOR:  f = r_op ^ s_op;
            fp_slice_pkg::FN_EXNOR: f = ~(r_op ^ s_op);
        endcase
        unique case (fill_q)
            fp_slice_pkg::FILL_ZERO:  begin dn_fill = 1'b0; up_fill = 1'b0; end
            fp_slice_pkg::FILL_ONE:   begin dn_fill = 1'b1; up_fill = 1'b1; end
            fp_slice_pkg::FILL_ROT:   begin dn_fill = f[0]; up_fill = f[63]; end
            fp_slice_pkg::FILL_CARRY: begin dn_fill = cout; up_fill = cout; end
        endcase
        // Q never rotates: a rotate fill puts a zero into Q
        q_fill = (fill_q == fp_slice_pkg::FILL_ONE) | ((fill_q == fp_slice_pkg::FILL_CARRY) & cout);
        rf_we = 1'b0;
        rf_wdata = f;
        next_q = q;
        unique case (dst_q)
            fp_slice_pkg::DST_QREG:  next_q = f;
            fp_slice_pkg::DST_NOP:   rf_we = 1'b0;
            fp_slice_pkg::DST_RAMA,
            fp_slice_pkg::DST_RAMF:  rf_we = 1'b1;
            fp_slice_pkg::DST_RAMQD: begin
                rf_we = 1'b1;
                rf_wdata = {dn_fill, f[63:1]};
                next_q = {f[0], q[63:1]};
            end
            fp_slice_pkg::DST_RAMD:  begin rf_we = 1'b1; rf_wdata = {dn_fill, f[63:1]}; end
            fp_slice_pkg::DST_RAMQU: begin
                rf_we = 1'b1;
                rf_wdata = {f[62:0], q[63]};
                next_q = {q[62:0], q_fill};
            end
            fp_slice_pkg::DST_RAMU:  begin rf_we = 1'b1; rf_wdata = {f[62:0], up_fill}; end
        endcase
        if (state != ST_EXEC) begin
            rf_we = 1'b0;
            next_q = q;
        end
        for (int k = 0; k < fp_slice_pkg::SECTORS; k++) begin
            if (!sect_q[k]) begin
                next_q[k*16 +: 16] = q[k*16 +: 16];
            end
        end
        y_out = (dst_q == fp_slice_pkg::DST_RAMA) ? a_word : f;
        next_xvalid = (state == ST_EXEC) && drive_q;
        next_xout = operand_transfer_bus_out;
        if (next_xvalid) begin
            next_xout = from_alu_q ? y_out[{word_q, 4'h0} +: 16] : a_word[{word_q, 4'h0} +: 16];
        end
        next_flags = flags;
        next_fco = fast_carry_out;
        if (state == ST_EXEC) begin
            next_flags[fp_slice_pkg::ST_CARRY] = cout;
            next_flags[fp_slice_pkg::ST_ZERO] = (f == 64'h0);
            next_flags[fp_slice_pkg::ST_SIGN] = f[63];
            next_flags[fp_slice_pkg::ST_OVF] = cb[63] ^ cout;
            next_fco = cout;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= 64'h0;
            flags <= 4'h0;
            fast_carry_out <= 1'b0;
            operand_transfer_bus_out <= 16'h0000;
            xfer_out_valid <= 1'b0;
        end else if (ce) begin
            q <= next_q;
            flags <= next_flags;
            fast_carry_out <= next_fco;
            operand_transfer_bus_out <= next_xout;
            xfer_out_valid <= next_xvalid;
        end
    end

    // Register port
    always_comb begin
        next_ir = ir;
        if (reg_wr && reg_addr == fp_slice_pkg::REG_IR) begin
            next_ir = reg_wdata[11:0];
        end
        next_rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == fp_slice_pkg::REG_IR) begin
                next_rdata = {4'h0, ir};
            end else if (reg_addr == fp_slice_pkg::REG_STATUS) begin
                next_rdata = {11'h000, busy, flags};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ir <= fp_slice_pkg::IR_RESET;
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            ir <= next_ir;
            reg_rdata <= next_rdata;
        end
    end

    a_ir_addr_range: assert property (@(posedge clk) disable iff (srst)
        (a_port_sel != fp_slice_pkg::PSEL_CTL) |-> !a_eff[3]) else $error("IR selection reached high bank");
    a_ac_field_map: assert property (@(posedge clk) disable iff (srst)
        (b_port_sel == fp_slice_pkg::PSEL_IR_AC) |-> b_eff == {2'b00, ir[7:6]}) else $error("accumulator address wrong");
    a_done_after_go: assert property (@(posedge clk) disable iff (srst)
        ce && state == ST_IDLE && mc_go ##1 ce |=> mc_done) else $error("microcycle did not finish");
    a_cla_sum: assert property (@(posedge clk) disable iff (srst)
        {cout, p ^ cb} == ({1'b0, x_op} + {1'b0, y_op} + {64'h0, cin_q})) else $error("carry look-ahead sum wrong");
    a_q_pair_shift: assert property (@(posedge clk) disable iff (srst)
        ce && state == ST_EXEC && dst_q == fp_slice_pkg::DST_RAMQD && sect_q == 4'hF
        |=> q == {$past(f[0]), $past(q[63:1])}) else $error("Q right shift wrong");
    a_q_shift_alone: assert property (@(posedge clk) disable iff (srst)
        ce && (dst_q == fp_slice_pkg::DST_RAMD || dst_q == fp_slice_pkg::DST_RAMU || dst_q == fp_slice_pkg::DST_NOP)
        |=> $stable(q)) else $error("Q moved without register file");
    a_rotate_full: assert property (@(posedge clk) disable iff (srst)
        dst_q == fp_slice_pkg::DST_RAMD && fill_q == fp_slice_pkg::FILL_ROT
        |-> rf_wdata == {f[0], f[63:1]}) else $error("rotate wrong");
    a_carry_link: assert property (@(posedge clk) disable iff (srst)
        dst_q == fp_slice_pkg::DST_RAMU && fill_q == fp_slice_pkg::FILL_CARRY
        |-> rf_wdata[0] == cout && rf_wdata[63:1] == f[62:0]) else $error("carry not linked");
    a_xfer_word: assert property (@(posedge clk) disable iff (srst)
        ce && state == ST_EXEC && drive_q && !from_alu_q
        |=> xfer_out_valid && operand_transfer_bus_out == $past(a_word[{word_q, 4'h0} +: 16]))
        else $error("transfer word wrong");
endmodule : fp_bit_slice_datapath

// ==== transfer_word_source.sv ====
module transfer_word_source (
    input  wire logic        clk,
    input  wire logic        mc_go,
    input  wire logic [15:0] word,
    output logic      [15:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last = 16'h0000;
    // Idle bus shows the inverse of the last word, so a late sample cannot pass
    assign bus = mc_go ? word : ~last;
    always @(posedge clk) begin
        if (mc_go) begin
            last <= word;
        end
    end
endmodule : transfer_word_source

// ==== fp_bit_slice_datapath_bench.sv ====
module fp_bit_slice_datapath_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                      clk = 1'b0;
    logic                      srst = 1'b1;
    logic                      mc_go = 1'b0;
    logic                      reg_wr = 1'b0;
    logic                      reg_rd = 1'b0;
    logic                      xfer_drive = 1'b0;
    logic                      xfer_from_alu = 1'b0;
    logic                      xfer_out_valid, mc_done, busy, fast_carry_out;
    fp_slice_pkg::port_sel_e   a_port_sel = fp_slice_pkg::PSEL_CTL;
    fp_slice_pkg::port_sel_e   b_port_sel = fp_slice_pkg::PSEL_CTL;
    fp_slice_pkg::port_sel_e   pa = fp_slice_pkg::PSEL_CTL;
    fp_slice_pkg::port_sel_e   pb = fp_slice_pkg::PSEL_CTL;
    fp_slice_pkg::alu_src_e    alu_source = fp_slice_pkg::SRC_DZ;
    fp_slice_pkg::alu_dst_e    alu_dest = fp_slice_pkg::DST_NOP;
    fp_slice_pkg::alu_fn_e     alu_function = fp_slice_pkg::FN_ADD;
    fp_slice_pkg::alu_fn_e     fn = fp_slice_pkg::FN_ADD;
    logic                      carry_in = 1'b0;
    logic                      cin = 1'b0;
    fp_slice_pkg::shift_fill_e shift_fill = fp_slice_pkg::FILL_ZERO;
    logic [3:0]                a_field = 4'h0;
    logic [3:0]                b_field = 4'h0;
    logic [3:0]                sector_load = 4'h0;
    logic [1:0]                word_sel = 2'h0;
    logic [1:0]                reg_addr = 2'h0;
    logic [15:0]               word = 16'h0000;
    logic [15:0]               reg_wdata = 16'h0000;
    logic [15:0]               bus_in, bus_out, reg_rdata;
    int                        fails = 0;
    int                        comparisons = 0;

    always #25 clk = ~clk;

    transfer_word_source i_src (.clk, .mc_go, .word, .bus(bus_in));

    fp_bit_slice_datapath i_dut (
        .clk, .srst, .ce(1'b1), .mc_go, .a_port_sel, .b_port_sel, .a_field, .b_field, .alu_source,
        .alu_function, .alu_dest, .carry_in, .shift_fill, .sector_load,
        .word_sel, .xfer_drive, .xfer_from_alu, .operand_transfer_bus_in(bus_in),
        .operand_transfer_bus_out(bus_out), .xfer_out_valid, .mc_done, .busy, .fast_carry_out,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
    );

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic complete_run;
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic mc(input logic [3:0] af, bf, input fp_slice_pkg::alu_src_e s, input fp_slice_pkg::alu_dst_e d,
                      input fp_slice_pkg::shift_fill_e f, input logic [3:0] sl, input logic [1:0] ws,
                      input logic drv, fa, input logic [15:0] w);
        @(posedge clk);
        mc_go <= 1'b1;
        a_port_sel <= pa;
        b_port_sel <= pb;
        a_field <= af;
        b_field <= bf;
        alu_source <= s;
        alu_dest <= d;
        alu_function <= fn;
        carry_in <= cin;
        shift_fill <= f;
        sector_load <= sl;
        word_sel <= ws;
        xfer_drive <= drv;
        xfer_from_alu <= fa;
        word <= w;
        @(posedge clk);
        mc_go <= 1'b0;
        #1;
        chk(64'(busy), 64'h1);
        @(posedge clk);
        #1;
        chk(64'({busy, mc_done}), 64'h1);
    endtask : mc

    task automatic ld64(input logic [3:0] bf, input logic [63:0] v);
        for (int k = 0; k < 4; k++) begin
            mc(4'h0, bf, fp_slice_pkg::SRC_DZ, fp_slice_pkg::DST_RAMF, fp_slice_pkg::FILL_ZERO,
               4'(1 << k), 2'(k), 1'b0, 1'b0, v[16*k+:16]);
        end
    endtask : ld64

    task automatic rd64(input logic [3:0] af, input fp_slice_pkg::alu_src_e s, input logic fa, input logic [63:0] e);
        for (int k = 0; k < 4; k++) begin
            mc(af, 4'h0, s, fp_slice_pkg::DST_NOP, fp_slice_pkg::FILL_ZERO, 4'h0, 2'(k), 1'b1, fa, 16'h0000);
            chk({xfer_out_valid, bus_out}, {1'b1, e[16*k+:16]});
        end
    endtask : rd64

    task automatic op(input logic [3:0] af, bf, input fp_slice_pkg::alu_src_e s, input fp_slice_pkg::alu_dst_e d,
                      input fp_slice_pkg::shift_fill_e f);
        mc(af, bf, s, d, f, 4'hF, 2'h0, 1'b0, 1'b0, 16'h0000);
    endtask : op

    task automatic reg_op(input logic w, input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!w) chk(64'(reg_rdata), 64'(d));
    endtask : reg_op

    task automatic sc_regfile;
        ld64(4'h0, 64'h0123_4567_89AB_CDEF);
        ld64(4'hF, 64'hFEDC_BA98_7654_3210);
        mc(4'h0, 4'h0, fp_slice_pkg::SRC_DZ, fp_slice_pkg::DST_RAMF, fp_slice_pkg::FILL_ZERO,
           4'h2, 2'h1, 1'b0, 1'b0, 16'hAAAA);
        rd64(4'h0, fp_slice_pkg::SRC_ZA, 1'b0, 64'h0123_4567_AAAA_CDEF);
        rd64(4'hF, fp_slice_pkg::SRC_ZA, 1'b0, 64'hFEDC_BA98_7654_3210);
        ld64(4'h0, 64'h0123_4567_89AB_CDEF);
    endtask : sc_regfile

    task automatic sc_carry;
        ld64(4'h1, 64'hFFFF_FFFF_FFFF_FFFF);
        ld64(4'h2, 64'h1);
        op(4'h1, 4'h2, fp_slice_pkg::SRC_AB, fp_slice_pkg::DST_RAMF, fp_slice_pkg::FILL_ZERO);
        chk(64'(fast_carry_out), 64'h1);
        reg_op(1'b0, fp_slice_pkg::REG_STATUS, 16'h0003);
        rd64(4'h2, fp_slice_pkg::SRC_ZA, 1'b0, 64'h0);
        op(4'h1, 4'h1, fp_slice_pkg::SRC_AB, fp_slice_pkg::DST_RAMD, fp_slice_pkg::FILL_CARRY);
        rd64(4'h1, fp_slice_pkg::SRC_ZA, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF);
        fn = fp_slice_pkg::FN_SUBR;
        cin = 1'b1;
        mc(4'h1, 4'h4, fp_slice_pkg::SRC_DA, fp_slice_pkg::DST_RAMF, fp_slice_pkg::FILL_ZERO,
           4'hF, 2'h0, 1'b0, 1'b0, 16'h0005);
        chk(64'(fast_carry_out), 64'h1);
        fn = fp_slice_pkg::FN_EXOR;
        cin = 1'b0;
        mc(4'h4, 4'h4, fp_slice_pkg::SRC_DA, fp_slice_pkg::DST_RAMF, fp_slice_pkg::FILL_ZERO,
           4'hF, 2'h0, 1'b1, 1'b1, 16'h000F);
        chk({xfer_out_valid, bus_out}, {1'b1, 16'hFFF5});
        fn = fp_slice_pkg::FN_ADD;
        op(4'h1, 4'h4, fp_slice_pkg::SRC_AB, fp_slice_pkg::DST_RAMU, fp_slice_pkg::FILL_CARRY);
        rd64(4'h4, fp_slice_pkg::SRC_ZA, 1'b0, 64'hFFFF_FFFF_FFFF_FFE9);
    endtask : sc_carry

    task automatic sc_shift;
        op(4'h0, 4'h5, fp_slice_pkg::SRC_ZA, fp_slice_pkg::DST_RAMU, fp_slice_pkg::FILL_ZERO);
        rd64(4'h5, fp_slice_pkg::SRC_ZA, 1'b0, 64'h0246_8ACF_1357_9BDE);
        op(4'h0, 4'h5, fp_slice_pkg::SRC_ZA, fp_slice_pkg::DST_RAMD, fp_slice_pkg::FILL_ROT);
        rd64(4'h5, fp_slice_pkg::SRC_ZA, 1'b0, 64'h8091_A2B3_C4D5_E6F7);
        op(4'h0, 4'h5, fp_slice_pkg::SRC_ZA, fp_slice_pkg::DST_RAMU, fp_slice_pkg::FILL_ONE);
        rd64(4'h0, fp_slice_pkg::SRC_ZA, 1'b1, 64'h0123_4567_89AB_CDEF);
        rd64(4'h5, fp_slice_pkg::SRC_ZA, 1'b0, 64'h0246_8ACF_1357_9BDF);
    endtask : sc_shift

    task automatic sc_q;
        op(4'h0, 4'h0, fp_slice_pkg::SRC_ZA, fp_slice_pkg::DST_QREG, fp_slice_pkg::FILL_ZERO);
        op(4'h0, 4'h8, fp_slice_pkg::SRC_ZA, fp_slice_pkg::DST_RAMQU, fp_slice_pkg::FILL_ONE);
        rd64(4'h0, fp_slice_pkg::SRC_ZQ, 1'b1, 64'h0246_8ACF_1357_9BDF);
        rd64(4'h8, fp_slice_pkg::SRC_ZA, 1'b0, 64'h0246_8ACF_1357_9BDE);
        op(4'h0, 4'h9, fp_slice_pkg::SRC_ZA, fp_slice_pkg::DST_RAMD, fp_slice_pkg::FILL_ZERO);
        rd64(4'h0, fp_slice_pkg::SRC_ZQ, 1'b1, 64'h0246_8ACF_1357_9BDF);
        op(4'h8, 4'h9, fp_slice_pkg::SRC_ZA, fp_slice_pkg::DST_RAMQD, fp_slice_pkg::FILL_ROT);
        rd64(4'h0, fp_slice_pkg::SRC_ZQ, 1'b1, 64'h0123_4567_89AB_CDEF);
        rd64(4'h9, fp_slice_pkg::SRC_ZA, 1'b0, 64'h0123_4567_89AB_CDEF);
    endtask : sc_q

    task automatic sc_ir;
        reg_op(1'b0, fp_slice_pkg::REG_IR, 16'h0000);
        reg_op(1'b1, fp_slice_pkg::REG_IR, 16'hF083);
        reg_op(1'b0, fp_slice_pkg::REG_IR, 16'h0083);
        reg_op(1'b0, 2'h3, 16'h0000);
        pb = fp_slice_pkg::PSEL_IR_SD;
        ld64(4'hC, 64'h5A5A_0F0F_3C3C_9696);
        pb = fp_slice_pkg::PSEL_CTL;
        rd64(4'h3, fp_slice_pkg::SRC_ZA, 1'b0, 64'h5A5A_0F0F_3C3C_9696);
        pa = fp_slice_pkg::PSEL_IR_AC;
        pb = fp_slice_pkg::PSEL_IR_AC;
        rd64(4'h0, fp_slice_pkg::SRC_ZA, 1'b0, 64'h0);
        pa = fp_slice_pkg::PSEL_CTL;
        pb = fp_slice_pkg::PSEL_CTL;
    endtask : sc_ir

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        sc_regfile();
        sc_carry();
        sc_shift();
        sc_q();
        sc_ir();
        complete_run();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #(50 * 5000);
        fails++;
        complete_run();
    end
endmodule : fp_bit_slice_datapath_bench
